//--- lbs_pkg.sv
/*
  Shared constants, types and helpers of the LED behavior sequencer.
  Assumes a single 10 MHz clock and one register bus master.
*/
package lbs_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned STEP_MS        = 32;
  localparam int unsigned TICKS_PER_STEP = STEP_MS / TICK_MS;
  localparam logic [3:0]  PWM_LAST       = 4'hE;

  // ==========================================================================
  // Register indexes, byte address is four times the index
  localparam logic [7:0] IDX_BEHAV_LOW  = 8'h81;
  localparam logic [7:0] IDX_BEHAV_HIGH = 8'h82;
  localparam logic [7:0] IDX_P1_PERIOD  = 8'h84;
  localparam logic [7:0] IDX_OUT_CTRL   = 8'hA0;
  localparam logic [7:0] IDX_LINK       = 8'hA1;
  localparam logic [7:0] IDX_COUNT      = 8'hA2;
  localparam logic [7:0] IDX_DUTY_BASE  = 8'hA3;
  localparam logic [7:0] IDX_P2_PERIOD  = 8'hA7;
  localparam logic [7:0] IDX_BR_PERIOD  = 8'hA8;
  localparam logic [7:0] IDX_STATUS     = 8'hA9;

  // ==========================================================================
  // Reset values and field positions
  localparam logic [7:0] RST_BEHAV     = 8'h00;
  localparam logic [7:0] RST_P1_PERIOD = 8'h20;
  localparam logic [7:0] RST_P2_PERIOD = 8'h14;
  localparam logic [7:0] RST_BR_PERIOD = 8'h5D;
  localparam logic [7:0] RST_COUNT     = 8'h04;
  localparam logic [7:0] RST_DUTY      = 8'hF0;
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam int unsigned START_SEL_BIT = 7;
  localparam int unsigned CNT2_LSB      = 3;
  localparam int unsigned DUTY_MAX_LSB  = 4;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {LBS_DIRECT, LBS_PULSE1, LBS_PULSE2, LBS_BREATHE} lbs_behav_t;
  typedef enum logic [1:0] {LBS_IDLE, LBS_HOLD, LBS_COUNT} lbs_chan_state_t;

  typedef struct packed {
    lbs_behav_t  behav;
    logic        start_sel;
    logic [6:0]  period;
    logic [2:0]  count;
    logic [3:0]  dmin;
    logic [3:0]  dmax;
  } lbs_cfg_t;

  // Period in ticks; code zero behaves as code one.
  function automatic logic [11:0] lbs_period_ticks(input logic [6:0] code);
    logic [6:0] eff;
    eff = (code == 7'h00) ? 7'h01 : code;
    return 12'(eff * TICKS_PER_STEP);
  endfunction : lbs_period_ticks

endpackage : lbs_pkg

//--- lbs_channel.sv
/*
  One LED channel: behavior state machine and brightness ramp.
  Assumes a one-cycle tick every millisecond and a shared PWM phase.
*/
`timescale 1ns/1ns
module lbs_channel
  import lbs_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       tick_in,
  input  wire logic       src_in,
  input  wire logic [3:0] pwm_phase_in,
  input  wire lbs_cfg_t   cfg_in,
  output logic            active_out,
  output logic            busy_out
);

  lbs_chan_state_t state_q, state_d;
  logic            src_q, down_q, down_d;
  logic [11:0]     phase_q, phase_d, acc_q, acc_d, acc_n, per;
  logic [3:0]      level_q, level_d, remain_q, remain_d, span;
  logic            rise, fall, pulse_end;

  // ==========================================================================
  // Sequencer
  always_comb begin
    rise      = src_in & ~src_q;
    fall      = ~src_in & src_q;
    per       = lbs_period_ticks(cfg_in.period);
    span      = (cfg_in.dmax > cfg_in.dmin) ? 4'(cfg_in.dmax - cfg_in.dmin) : 4'h0;
    pulse_end = tick_in && (state_q != LBS_IDLE) && (phase_q == per - 12'h001);
    state_d   = state_q;
    remain_d  = remain_q;
    phase_d   = phase_q;
    acc_d     = acc_q;
    down_d    = down_q;
    level_d   = level_q;
    acc_n     = acc_q + 12'({span, 1'b0});
    case (state_q)
      LBS_IDLE: begin
        phase_d = 12'h000;
        acc_d   = 12'h000;
        down_d  = 1'b0;
        level_d = (cfg_in.behav == LBS_DIRECT && src_in) ? cfg_in.dmax : cfg_in.dmin;
        if (cfg_in.behav == LBS_PULSE1 && (cfg_in.start_sel ? fall : rise)) begin
          state_d  = LBS_COUNT;
          remain_d = {1'b0, cfg_in.count};
        end else if (cfg_in.behav != LBS_PULSE1 && cfg_in.behav != LBS_DIRECT && rise) begin
          state_d  = LBS_HOLD;
        end
      end
      LBS_HOLD: begin
        if (cfg_in.behav == LBS_PULSE2 && fall) begin
          state_d  = LBS_COUNT;
          remain_d = 4'({1'b0, cfg_in.count} + 4'h1);
        end else if (cfg_in.behav != LBS_PULSE2 && fall) begin
          state_d  = LBS_IDLE;
        end
      end
      LBS_COUNT: begin
        if (pulse_end) begin
          if (remain_q == 4'h0) state_d = LBS_IDLE;
          else remain_d = remain_q - 4'h1;
        end
      end
      default: state_d = LBS_IDLE;
    endcase
    // Error-free ramp: at most one level step per tick as 2*span < period.
    if (state_q != LBS_IDLE && tick_in) begin
      if (phase_q == per - 12'h001) begin
        phase_d = 12'h000;
        acc_d   = 12'h000;
        down_d  = 1'b0;
        level_d = cfg_in.dmin;
      end else begin
        phase_d = phase_q + 12'h001;
        if (phase_q + 12'h001 == (per >> 1)) down_d = 1'b1;
        acc_d = acc_n;
        if (acc_n >= per) begin
          acc_d   = acc_n - per;
          level_d = down_q ? level_q - 4'h1 : level_q + 4'h1;
        end
      end
    end
    active_out = level_q > pwm_phase_in;
    busy_out   = state_q != LBS_IDLE;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q  <= LBS_IDLE;
      src_q    <= 1'b0;
      phase_q  <= 12'h000;
      acc_q    <= 12'h000;
      down_q   <= 1'b0;
      level_q  <= 4'h0;
      remain_q <= 4'h0;
    end else begin
      state_q  <= state_d;
      src_q    <= src_in;
      phase_q  <= phase_d;
      acc_q    <= acc_d;
      down_q   <= down_d;
      level_q  <= level_d;
      remain_q <= remain_d;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence tail_start_s;
    state_q == LBS_HOLD && cfg_in.behav == LBS_PULSE2 && fall;
  endsequence

  direct_follow_a: assert property ((state_q == LBS_IDLE && cfg_in.behav == LBS_DIRECT
    && src_in) |=> level_q == $past(cfg_in.dmax)) else $error("direct level wrong");
  pulse_start_a: assert property ((state_q == LBS_IDLE && cfg_in.behav == LBS_PULSE1
    && cfg_in.start_sel && fall) |=> (state_q == LBS_COUNT && remain_q == $past(cfg_in.count)))
    else $error("counted pulse start wrong");
  tail_load_a: assert property (tail_start_s |=> (state_q == LBS_COUNT
    && remain_q == $past(cfg_in.count) + 4'h1)) else $error("tail count wrong");
  pulse_finish_a: assert property ((state_q == LBS_COUNT && remain_q == 4'h0 && pulse_end)
    |=> state_q == LBS_IDLE) else $error("pulse train did not end");
  breathe_stop_a: assert property ((state_q == LBS_HOLD && cfg_in.behav == LBS_BREATHE
    && fall) |=> state_q == LBS_IDLE) else $error("breathe did not stop");
  ramp_bound_a: assert property ((state_q != LBS_IDLE && $stable(cfg_in) &&
    cfg_in.dmax > cfg_in.dmin && $past(state_q) != LBS_IDLE) |-> (level_q >= cfg_in.dmin
    && level_q <= cfg_in.dmax)) else $error("level out of range");

endmodule : lbs_channel

//--- lbs_top.sv
/*
  LED behavior sequencer top: Avalon-MM register slave, millisecond
  divider, touch synchronisers, PWM phase and eight channels.
  Assumes touch inputs are asynchronous levels, high while touched.
*/
// Added by the designer: the Avalon-MM slave port.
// Contract
// - Low behavior register holds channel 4..1 selectors, two bits each, top down.
// - High behavior register holds channel 8..5 selectors, two bits each, top down.
// - Direct: output on while touched or control bit set, off otherwise.
// - Counted pulse: start trigger runs programmed pulses min-max-min; no stop trigger.
// - Pulse while held; on release run programmed further pulses, then rest minimum.
// - Breathe: ramp min to max and back, each ramp half the period.
// - PWM rate follows behavior; direct uses maximum rate with zero rise/fall. All channels here share one PWM phase that steps every clock.
// - Counted pulse period is a 7-bit code in 32 ms steps.
// - Period equals code times 32 ms, code zero gives 32 ms.
// - Counted pulse period register resets to 20h, 1024 ms, start edge cleared.
// - Start-edge bit: 0 starts on touch or set, 1 on release or clear.
// - Very short periods run at the shortest period the limits allow.
// - Linked channels trigger from sensor; unlinked ones from the control bit.
// - A 3-bit count n gives n plus one pulses.
// - Each behavior ramps between its own 4-bit minimum and maximum duty.
`timescale 1ns/1ns
module lbs_top
  import lbs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
)(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [7:0]  touch_in,
  output logic [7:0]       led_out
);

  // ==========================================================================
  // Declarations
  logic [7:0]  behav_low_q, behav_low_d;
  logic [7:0]  behav_high_q, behav_high_d;
  logic [7:0]  p1per_q, p1per_d;
  logic [7:0]  p2per_q, p2per_d;
  logic [7:0]  brper_q, brper_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  link_q, link_d;
  logic [7:0]  count_q, count_d;
  logic [7:0]  duty_q [4];
  logic [7:0]  duty_d [4];
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  idx;
  logic        wr_commit;
  logic [7:0]  wbyte;
  logic [15:0] behav_all;

  logic [7:0]  touch_meta_q, touch_sync_q;
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic        tick_q, tick_d;
  logic [3:0]  pwm_q, pwm_d;
  logic [7:0]  led_d;
  logic [7:0]  src, active, busy;
  lbs_cfg_t    cfg [8];

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] duty_slot(input lbs_behav_t b);
    case (b)
      LBS_PULSE1:  return 8'h00;
      LBS_PULSE2:  return 8'h01;
      LBS_BREATHE: return 8'h02;
      default:     return 8'h03;
    endcase
  endfunction : duty_slot

  function automatic lbs_cfg_t chan_cfg(input logic [1:0] code, input logic [7:0] duty,
                                        input logic [7:0] p1, input logic [7:0] p2,
                                        input logic [7:0] br, input logic [7:0] cnt);
    lbs_cfg_t c;
    c.behav     = lbs_behav_t'(code);
    c.start_sel = p1[START_SEL_BIT];
    c.dmin      = duty[3:0];
    c.dmax      = duty[DUTY_MAX_LSB +: 4];
    c.count     = cnt[2:0];
    c.period    = p1[6:0];
    if (c.behav == LBS_PULSE2) begin
      c.period = p2[6:0];
      c.count  = cnt[CNT2_LSB +: 3];
    end else if (c.behav == LBS_BREATHE) begin
      c.period = br[6:0];
    end
    return c;
  endfunction : chan_cfg

  // ==========================================================================
  // Register slave
  // A request is answered one cycle after it is seen; the write lands and
  // read data is valid in the single cycle that waitrequest is low.
  always_comb begin
    idx          = avs_address_in[9:2];
    wr_commit    = avs_write_in && !wait_q && avs_byteenable_in[0];
    wbyte        = avs_writedata_in[7:0];
    wait_d       = 1'b1;
    rdata_d      = rdata_q;
    behav_low_d  = behav_low_q;
    behav_high_d = behav_high_q;
    p1per_d      = p1per_q;
    p2per_d      = p2per_q;
    brper_d      = brper_q;
    ctrl_d       = ctrl_q;
    link_d       = link_q;
    count_d      = count_q;
    for (int i = 0; i < 4; i++) begin
      duty_d[i] = duty_q[i];
    end
    if ((avs_read_in || avs_write_in) && wait_q) begin
      wait_d  = 1'b0;
      rdata_d = 32'h0000_0000;
      case (idx)
        IDX_BEHAV_LOW:  rdata_d[7:0] = behav_low_q;
        IDX_BEHAV_HIGH: rdata_d[7:0] = behav_high_q;
        IDX_P1_PERIOD:  rdata_d[7:0] = p1per_q;
        IDX_OUT_CTRL:   rdata_d[7:0] = ctrl_q;
        IDX_LINK:       rdata_d[7:0] = link_q;
        IDX_COUNT:      rdata_d[7:0] = count_q;
        IDX_P2_PERIOD:  rdata_d[7:0] = p2per_q;
        IDX_BR_PERIOD:  rdata_d[7:0] = brper_q;
        IDX_STATUS:     rdata_d[7:0] = busy;
        default: begin
          if (idx >= IDX_DUTY_BASE && idx < IDX_DUTY_BASE + 8'h04) begin
            rdata_d[7:0] = duty_q[2'(idx - IDX_DUTY_BASE)];
          end
        end
      endcase
    end
    if (wr_commit) begin
      case (idx)
        IDX_BEHAV_LOW:  behav_low_d  = wbyte;
        IDX_BEHAV_HIGH: behav_high_d = wbyte;
        IDX_P1_PERIOD:  p1per_d      = wbyte;
        IDX_OUT_CTRL:   ctrl_d       = wbyte;
        IDX_LINK:       link_d       = wbyte;
        IDX_COUNT:      count_d      = {2'b00, wbyte[5:0]};
        IDX_P2_PERIOD:  p2per_d      = {1'b0, wbyte[6:0]};
        IDX_BR_PERIOD:  brper_d      = {1'b0, wbyte[6:0]};
        default: begin
          if (idx >= IDX_DUTY_BASE && idx < IDX_DUTY_BASE + 8'h04) begin
            duty_d[2'(idx - IDX_DUTY_BASE)] = wbyte;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q       <= 1'b1;
      rdata_q      <= 32'h0000_0000;
      behav_low_q  <= RST_BEHAV;
      behav_high_q <= RST_BEHAV;
      p1per_q      <= RST_P1_PERIOD;
      p2per_q      <= RST_P2_PERIOD;
      brper_q      <= RST_BR_PERIOD;
      ctrl_q       <= RST_CTRL;
      link_q       <= RST_CTRL;
      count_q      <= RST_COUNT;
      for (int i = 0; i < 4; i++) begin
        duty_q[i] <= RST_DUTY;
      end
    end else begin
      wait_q       <= wait_d;
      rdata_q      <= rdata_d;
      behav_low_q  <= behav_low_d;
      behav_high_q <= behav_high_d;
      p1per_q      <= p1per_d;
      p2per_q      <= p2per_d;
      brper_q      <= brper_d;
      ctrl_q       <= ctrl_d;
      link_q       <= link_d;
      count_q      <= count_d;
      for (int i = 0; i < 4; i++) begin
        duty_q[i] <= duty_d[i];
      end
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;

  // ==========================================================================
  // Time base and PWM phase
  // The PWM phase steps every clock, the fastest rate the 15-step duty
  // scale allows.
  always_comb begin
    tick_cnt_d = tick_cnt_q + 16'h0001;
    tick_d     = 1'b0;
    if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 16'h0000;
      tick_d     = 1'b1;
    end
    pwm_d = (pwm_q == PWM_LAST) ? 4'h0 : pwm_q + 4'h1;
    led_d = active;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt_q   <= 16'h0000;
      tick_q       <= 1'b0;
      pwm_q        <= 4'h0;
    end else begin
      tick_cnt_q   <= tick_cnt_d;
      tick_q       <= tick_d;
      pwm_q        <= pwm_d;
    end
  end

  // ==========================================================================
  // Touch synchroniser and LED output register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      touch_meta_q <= 8'h00;
      touch_sync_q <= 8'h00;
      led_out      <= 8'h00;
    end else begin
      touch_meta_q <= touch_in;
      touch_sync_q <= touch_meta_q;
      led_out      <= led_d;
    end
  end

  // ==========================================================================
  // Channels
  // Both behavior bytes are joined first, since a concatenation cannot be indexed.
  assign behav_all = {behav_high_q, behav_low_q};

  for (genvar g = 0; g < 8; g++) begin : g_chan
    assign src[g] = link_q[g] ? touch_sync_q[g] : ctrl_q[g];
    assign cfg[g] = chan_cfg(behav_all[2*g +: 2],
                             duty_q[2'(duty_slot(lbs_behav_t'(behav_all[2*g +: 2])))],
                             p1per_q, p2per_q, brper_q, count_q);
    lbs_channel u_chan (
      .clk_in       (clk_in),
      .resetn_in    (resetn_in),
      .tick_in      (tick_q),
      .src_in       (src[g]),
      .pwm_phase_in (pwm_q),
      .cfg_in       (cfg[g]),
      .active_out   (active[g]),
      .busy_out     (busy[g])
    );
  end

  // ==========================================================================
  // Checks
  sequence bus_req_s;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence

  sequence bus_ans_s;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  property bus_answer_p;
    @(posedge clk_in) disable iff (!resetn_in) bus_req_s |=> bus_ans_s;
  endproperty

  bus_answer_a: assert property (bus_answer_p) else $error("bus answer late");

  period_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
     && avs_address_in[9:2] == IDX_P1_PERIOD) |=> p1per_q == $past(avs_writedata_in[7:0]))
    else $error("pulse period write lost");

  behav_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (avs_read_in && avs_waitrequest_out && avs_address_in[9:2] == IDX_BEHAV_LOW)
    |=> avs_readdata_out == {24'h000000, $past(behav_low_q)})
    else $error("behavior read wrong");

  period_reset_a: assert property (@(posedge clk_in)
    $rose(resetn_in) |-> p1per_q == RST_P1_PERIOD)
    else $error("period reset value wrong");

  led_register_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ##1 led_out == $past(active)) else $error("led output not registered");

  tick_spacing_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tick_q |=> !tick_q) else $error("tick too dense");

  behav_high_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (avs_read_in && avs_waitrequest_out && avs_address_in[9:2] == IDX_BEHAV_HIGH)
    |=> avs_readdata_out == {24'h000000, $past(behav_high_q)})
    else $error("high behavior read wrong");

  lane_guard_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (avs_write_in && !avs_waitrequest_out && !avs_byteenable_in[0])
    |=> $stable({behav_low_q, behav_high_q, p1per_q}))
    else $error("masked write landed");

  status_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (avs_read_in && avs_waitrequest_out && avs_address_in[9:2] == IDX_STATUS)
    |=> avs_readdata_out == {24'h000000, $past(busy)})
    else $error("status read wrong");

endmodule : lbs_top

//--- lbs_led_model.sv
/*
  Model of the LEDs on the led pins: it counts the active clocks of each output.
  Assumes an output is high while its LED conducts, and that the bench pulses clr_in.
*/
`timescale 1ns/1ns
module lbs_led_model
  import lbs_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             clr_in,
  input  wire logic [7:0]       led_in,
  output logic      [7:0][15:0] on_cnt_out
);
  // ==========================================================================
  // Active-time counters
  logic [7:0][15:0] on_cnt_d;
  logic [7:0][15:0] on_cnt_q;

  // A duty figure only means something over a whole ramp, so the bench chooses the window.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      on_cnt_d[i] = clr_in ? 16'h0000 : on_cnt_q[i] + 16'(led_in[i]);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      on_cnt_q <= '0;
    end else begin
      on_cnt_q <= on_cnt_d;
    end
  end

  assign on_cnt_out = on_cnt_q;
endmodule : lbs_led_model

//--- lbs_top_tb_top.sv
/*
  Self-checking bench of lbs_top: Avalon-MM register tasks and behavior tests.
  Assumes TICK_CYCLES is cut to 4, so one 32 ms period step lasts 128 clocks.
*/
`timescale 1ns/1ns
module lbs_top_tb_top
  import lbs_pkg::*;
;
  localparam int unsigned TCK  = 4;
  localparam int unsigned STEP = TCK * TICKS_PER_STEP;
  logic             clk_in    = 1'b0;
  logic             resetn_in = 1'b0;
  logic [9:0]       address   = 10'h000;
  logic             read      = 1'b0;
  logic             write     = 1'b0;
  logic [31:0]      wdata     = 32'h00000000;
  logic [3:0]       be        = 4'h0;
  logic [7:0]       touch     = 8'h00;
  logic             cnt_clr   = 1'b0;
  logic [31:0]      rdata;
  logic             wreq;
  logic [7:0]       led;
  logic [7:0][15:0] on_cnt;
  logic [31:0]      v;
  int               fails     = 0;
  int               checked   = 0;
  int               cyc       = 0;
  int               t;

  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  lbs_top #(.TICK_CYCLES(TCK)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
    .avs_address_in(address), .avs_read_in(read), .avs_write_in(write),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .touch_in(touch), .led_out(led));
  lbs_led_model led_u (.clk_in(clk_in), .resetn_in(resetn_in), .clr_in(cnt_clr),
    .led_in(led), .on_cnt_out(on_cnt));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // The request is held until waitrequest is sampled low; the bound stops a hang and counts it as a failure.
  task automatic bus(input logic [7:0] idx, input logic wr_en, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_in);
    read    <= !wr_en;
    write   <= wr_en;
    address <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    be      <= b;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    v = rdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d, 4'h1);
  endtask : wr

  task automatic busy_time(input int t0);
    do bus(IDX_STATUS, 1'b0, 8'h00, 4'hF); while (v[0] === 1'b1 && cyc - t0 < 40000);
    t = cyc - t0;
  endtask : busy_time

  task automatic wait_count(input int n);
    @(posedge clk_in);
    cnt_clr <= 1'b1;
    @(posedge clk_in);
    cnt_clr <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask : wait_count

  task automatic pulse1(input logic sel, input logic [6:0] code, input logic [2:0] n);
    int t0;
    int e;
    wr(IDX_P1_PERIOD, {sel, code});
    wr(IDX_COUNT, {5'h00, n});
    t0 = cyc;
    wr(IDX_OUT_CTRL, 8'h01);
    repeat (40) @(posedge clk_in);
    bus(IDX_STATUS, 1'b0, 8'h00, 4'hF);
    chk(v[0], !sel);
    if (sel) t0 = cyc;
    wr(IDX_OUT_CTRL, 8'h00);
    busy_time(t0);
    e = (n + 1) * ((code == 7'h00) ? 1 : code) * STEP;
    chk(t >= e - 8 && t <= e + 24, 1'b1);
  endtask : pulse1

  task automatic results();
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // Tests
  initial begin
    #(100 * 80000);
    fails++;
    results();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus(IDX_BEHAV_LOW, 1'b0, 8'h00, 4'hF);
    chk(v, 32'h0);
    bus(IDX_BEHAV_HIGH, 1'b0, 8'h00, 4'hF);
    chk(v, 32'h0);
    bus(IDX_P1_PERIOD, 1'b0, 8'h00, 4'hF);
    chk(v, 32'h20);
    wr(IDX_BEHAV_LOW, 8'hE4);
    wr(IDX_BEHAV_HIGH, 8'h1B);
    bus(IDX_BEHAV_HIGH, 1'b1, 8'hFF, 4'hE);
    wr(8'h83, 8'h5A);
    bus(IDX_BEHAV_LOW, 1'b0, 8'h00, 4'hF);
    chk(v, 32'hE4);
    bus(IDX_BEHAV_HIGH, 1'b0, 8'h00, 4'hF);
    chk(v, 32'h1B);
    bus(8'h83, 1'b0, 8'h00, 4'hF);
    chk(v, 32'h0);
    wr(IDX_BEHAV_LOW, 8'h00);
    wr(IDX_BEHAV_HIGH, 8'h00);
    // Direct behavior: full duty is steady high, zero duty steady low.
    wr(IDX_OUT_CTRL, 8'hA5);
    repeat (10) @(posedge clk_in);
    chk(led, 8'hA5);
    wr(IDX_OUT_CTRL, 8'h5A);
    repeat (10) @(posedge clk_in);
    chk(led, 8'h5A);
    wr(IDX_OUT_CTRL, 8'h00);
    wr(IDX_LINK, 8'hFF);
    touch <= 8'h3C;
    repeat (10) @(posedge clk_in);
    chk(led, 8'h3C);
    touch <= 8'hC3;
    repeat (10) @(posedge clk_in);
    chk(led, 8'hC3);
    touch <= 8'h00;
    wr(IDX_LINK, 8'h00);
    // Counted pulse on channel 1.
    wr(IDX_BEHAV_LOW, 8'h01);
    pulse1(1'b0, 7'h00, 3'h0);
    pulse1(1'b0, 7'h01, 3'h1);
    pulse1(1'b0, 7'h02, 3'h0);
    pulse1(1'b1, 7'h01, 3'h7);
    // Pulse while held: runs while set, then the current pulse plus two more.
    wr(IDX_BEHAV_LOW, 8'h02);
    wr(IDX_P2_PERIOD, 8'h01);
    wr(IDX_COUNT, 8'h08);
    wr(IDX_OUT_CTRL, 8'h01);
    repeat (600) @(posedge clk_in);
    bus(IDX_STATUS, 1'b0, 8'h00, 4'hF);
    chk(v[0], 1'b1);
    wr(IDX_OUT_CTRL, 8'h00);
    busy_time(cyc);
    chk(t >= 248 && t <= 408, 1'b1);
    wait_count(200);
    chk(on_cnt[0], 16'h0);
    // Breathe over one 256-clock period, then with both limits at zero.
    wr(IDX_BEHAV_LOW, 8'h03);
    wr(IDX_BR_PERIOD, 8'h02);
    wr(IDX_OUT_CTRL, 8'h01);
    wait_count(256);
    chk(on_cnt[0] >= 64 && on_cnt[0] <= 192, 1'b1);
    wr(IDX_OUT_CTRL, 8'h00);
    wr(IDX_DUTY_BASE + 8'h02, 8'h00);
    wr(IDX_OUT_CTRL, 8'h01);
    wait_count(256);
    chk(on_cnt[0], 16'h0);
    wr(IDX_OUT_CTRL, 8'h00);
    // Field placement: channels 4 and 6 start counted pulses, the rest stay direct.
    wr(IDX_BEHAV_LOW, 8'h40);
    wr(IDX_BEHAV_HIGH, 8'h04);
    wr(IDX_P1_PERIOD, 8'h01);
    wr(IDX_OUT_CTRL, 8'h28);
    repeat (20) @(posedge clk_in);
    bus(IDX_STATUS, 1'b0, 8'h00, 4'hF);
    chk(v[7:0], 8'h28);
    results();
  end
endmodule : lbs_top_tb_top
